// file: rtl/tap_pkg.sv
package tap_pkg;

    // instruction register width and opcodes
    localparam int IR_W = 4;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_IDCODE = 4'h2;
    localparam logic [3:0] IR_HIGHZ = 4'h3;
    localparam logic [3:0] IR_BYPASS = 4'hf;

    // fixed pattern loaded while capturing the instruction
    localparam logic [3:0] IR_CAPTURE_PAT = 4'h1;

    // identification register layout
    localparam int ID_W = 32;
    localparam int ID_VER_POS = 28;
    localparam int ID_PART_POS = 12;
    localparam int ID_MFR_POS = 1;

    // bypass register reset value
    localparam logic BYPASS_RST = 1'b0;

    // depth of the pin-input and link synchronisers
    localparam int SYNC_STAGES = 2;

    // link clock period in the bench and core clock period, in ns
    localparam int TCK_PERIOD_NS = 320;
    localparam int CORE_PERIOD_NS = 40;
    // core cycles per link clock period
    localparam int TCK_CYCLES = TCK_PERIOD_NS / CORE_PERIOD_NS;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

endpackage : tap_pkg

// file: rtl/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// file: rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock, reset and enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // filling and draining sides
    stream_if.snk wr,
    stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr_ff;
    logic [AW:0] rptr_ff;
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    assign empty = (wptr_ff == rptr_ff);
    assign full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rptr_ff[AW-1:0]];
    assign do_wr = ce && wr.valid && !full;
    assign do_rd = ce && rd.ready && !empty;

    always_ff @(posedge core_clk)
    begin
        if (do_wr)
        begin
            mem[wptr_ff[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (do_rd)
            begin
                rptr_ff <= rptr_ff + 1'b1;
            end
        end
    end

endmodule : word_fifo

// file: rtl/tap_unit.sv
`timescale 1ns/1ps
module tap_unit #(
    parameter int BSR_LEN = 8,
    parameter int FIFO_DEPTH = 16,
    // arbitrary neutral identity values
    parameter logic [3:0] ID_VERSION = 4'h1,
    parameter logic [15:0] ID_PART = 16'h0001,
    parameter logic [10:0] ID_MAKER = 11'h001
) (
    // core clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // test access port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo_ff,
    output logic tdo_oe_n_ff,
    // device pins behind the boundary cells
    input wire logic [BSR_LEN-1:0] pad_in,
    input wire logic [BSR_LEN-1:0] core_out,
    input wire logic [BSR_LEN-1:0] core_oe_n,
    output logic [BSR_LEN-1:0] pad_out_ff,
    output logic [BSR_LEN-1:0] pad_oe_n_ff,
    // stream of updated boundary words
    output logic upd_valid_ff,
    output logic [BSR_LEN-1:0] upd_data_ff,
    input wire logic upd_ready
);
    localparam logic [tap_pkg::ID_W-1:0] ID_VALUE =
        ({28'h0, ID_VERSION} << tap_pkg::ID_VER_POS)
        | ({16'h0, ID_PART} << tap_pkg::ID_PART_POS)
        | ({21'h0, ID_MAKER} << tap_pkg::ID_MFR_POS) | 32'h1;

    logic arst_n;
    logic [2:0] tck_sh_ff;
    logic [1:0] tms_sh_ff;
    logic [1:0] tdi_sh_ff;
    logic [BSR_LEN-1:0] pad_s1_ff;
    logic [BSR_LEN-1:0] pad_s2_ff;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    tap_pkg::tap_state_t state_ff;
    tap_pkg::tap_state_t nxt_state;
    logic [tap_pkg::IR_W-1:0] ir_sh_ff;
    logic [tap_pkg::IR_W-1:0] ir_ff;
    logic [tap_pkg::ID_W-1:0] id_sh_ff;
    logic byp_ff;
    logic [BSR_LEN-1:0] bsr_sh_ff;
    logic [BSR_LEN-1:0] bsr_upd_ff;
    logic sel_id;
    logic sel_bsr;
    logic dr_lsb;

    stream_if #(.W(BSR_LEN)) fifo_wr ();
    stream_if #(.W(BSR_LEN)) fifo_rd ();

    // test reset acts on the unit alone, apart from any core reset
    assign arst_n = nrst & trst_n;

    // link pins pass two flops; a third flop only feeds edge detection
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tck_sh_ff <= '0;
            tms_sh_ff <= '1;
            tdi_sh_ff <= '0;
            pad_s1_ff <= '0;
            pad_s2_ff <= '0;
        end
        else if (ce)
        begin
            tck_sh_ff <= {tck_sh_ff[1:0], tck};
            tms_sh_ff <= {tms_sh_ff[0], tms};
            tdi_sh_ff <= {tdi_sh_ff[0], tdi};
            pad_s1_ff <= pad_in;
            pad_s2_ff <= pad_s1_ff;
        end
    end

    assign tck_rise = ce && tck_sh_ff[1] && !tck_sh_ff[2];
    assign tck_fall = ce && !tck_sh_ff[1] && tck_sh_ff[2];
    assign tms_s = tms_sh_ff[1];
    assign tdi_s = tdi_sh_ff[1];

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            tap_pkg::TEST_LOGIC_RESET:
                nxt_state = tms_s ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_IDLE;
            tap_pkg::RUN_IDLE:
                nxt_state = tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_IDLE;
            tap_pkg::SELECT_DR:
                nxt_state = tms_s ? tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
            tap_pkg::CAPTURE_DR:
                nxt_state = tms_s ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::SHIFT_DR:
                nxt_state = tms_s ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::EXIT1_DR:
                nxt_state = tms_s ? tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
            tap_pkg::PAUSE_DR:
                nxt_state = tms_s ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
            tap_pkg::EXIT2_DR:
                nxt_state = tms_s ? tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
            tap_pkg::UPDATE_DR:
                nxt_state = tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_IDLE;
            tap_pkg::SELECT_IR:
                nxt_state = tms_s ? tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
            tap_pkg::CAPTURE_IR:
                nxt_state = tms_s ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::SHIFT_IR:
                nxt_state = tms_s ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::EXIT1_IR:
                nxt_state = tms_s ? tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
            tap_pkg::PAUSE_IR:
                nxt_state = tms_s ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
            tap_pkg::EXIT2_IR:
                nxt_state = tms_s ? tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
            tap_pkg::UPDATE_IR:
                nxt_state = tms_s ? tap_pkg::SELECT_DR : tap_pkg::RUN_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= tap_pkg::TEST_LOGIC_RESET;
        end
        else if (tck_rise)
        begin
            state_ff <= nxt_state;
        end
    end

    // instruction shift stage: capture pattern, then shift from data input
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ir_sh_ff <= tap_pkg::IR_CAPTURE_PAT;
        end
        else if (tck_rise)
        begin
            if (state_ff == tap_pkg::CAPTURE_IR)
            begin
                ir_sh_ff <= tap_pkg::IR_CAPTURE_PAT;
            end
            else if (state_ff == tap_pkg::SHIFT_IR)
            begin
                ir_sh_ff <= {tdi_s, ir_sh_ff[tap_pkg::IR_W-1:1]};
            end
        end
    end

    // instruction parallel output, loaded on the falling link clock edge
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ir_ff <= tap_pkg::IR_IDCODE;
        end
        else if (tck_fall)
        begin
            if (state_ff == tap_pkg::TEST_LOGIC_RESET)
            begin
                ir_ff <= tap_pkg::IR_IDCODE;
            end
            else if (state_ff == tap_pkg::UPDATE_IR)
            begin
                ir_ff <= ir_sh_ff;
            end
        end
    end

    // unknown opcodes fall back to the bypass stage
    assign sel_id = (ir_ff == tap_pkg::IR_IDCODE);
    assign sel_bsr = (ir_ff == tap_pkg::IR_SAMPLE) || (ir_ff == tap_pkg::IR_EXTEST);

    // data registers: capture, then shift the active one toward the output
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            id_sh_ff <= '0;
            byp_ff <= tap_pkg::BYPASS_RST;
            bsr_sh_ff <= '0;
        end
        else if (tck_rise)
        begin
            if (state_ff == tap_pkg::CAPTURE_DR)
            begin
                if (sel_id)
                begin
                    id_sh_ff <= ID_VALUE;
                end
                else if (sel_bsr)
                begin
                    bsr_sh_ff <= pad_s2_ff;
                end
                else
                begin
                    byp_ff <= tap_pkg::BYPASS_RST;
                end
            end
            else if (state_ff == tap_pkg::SHIFT_DR)
            begin
                if (sel_id)
                begin
                    id_sh_ff <= {tdi_s, id_sh_ff[tap_pkg::ID_W-1:1]};
                end
                else if (sel_bsr)
                begin
                    bsr_sh_ff <= {tdi_s, bsr_sh_ff[BSR_LEN-1:1]};
                end
                else
                begin
                    byp_ff <= tdi_s;
                end
            end
        end
    end

    assign dr_lsb = sel_id ? id_sh_ff[0] : (sel_bsr ? bsr_sh_ff[0] : byp_ff);

    // serial output changes on the falling edge, floats outside shifting
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tdo_ff <= 1'b0;
            tdo_oe_n_ff <= 1'b1;
        end
        else if (tck_fall)
        begin
            if (state_ff == tap_pkg::SHIFT_IR)
            begin
                tdo_ff <= ir_sh_ff[0];
                tdo_oe_n_ff <= 1'b0;
            end
            else if (state_ff == tap_pkg::SHIFT_DR)
            begin
                tdo_ff <= dr_lsb;
                tdo_oe_n_ff <= 1'b0;
            end
            else
            begin
                tdo_oe_n_ff <= 1'b1;
            end
        end
    end

    // boundary update stage, preloaded ahead of an external test
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bsr_upd_ff <= '0;
        end
        else if (tck_fall && state_ff == tap_pkg::UPDATE_DR && sel_bsr)
        begin
            bsr_upd_ff <= bsr_sh_ff;
        end
    end

    // each updated boundary word is offered to the stream; a full buffer drops it
    assign fifo_wr.valid = tck_fall && state_ff == tap_pkg::UPDATE_DR && sel_bsr;
    assign fifo_wr.data = bsr_sh_ff;

    word_fifo #(.W(BSR_LEN), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .nrst(arst_n),
        .ce(ce),
        .wr(fifo_wr),
        .rd(fifo_rd)
    );

    assign fifo_rd.ready = ce && (!upd_valid_ff || upd_ready);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            upd_valid_ff <= 1'b0;
            upd_data_ff <= '0;
        end
        else if (ce && (!upd_valid_ff || upd_ready))
        begin
            upd_valid_ff <= fifo_rd.valid;
            upd_data_ff <= fifo_rd.data;
        end
    end

    // pins: core drives in normal mode and under sample, test logic under extest, all pins float under highz
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pad_out_ff <= '0;
            pad_oe_n_ff <= '1;
        end
        else if (ce)
        begin
            if (ir_ff == tap_pkg::IR_HIGHZ)
            begin
                pad_out_ff <= core_out;
                pad_oe_n_ff <= '1;
            end
            else if (ir_ff == tap_pkg::IR_EXTEST)
            begin
                pad_out_ff <= bsr_upd_ff;
                pad_oe_n_ff <= '0;
            end
            else
            begin
                pad_out_ff <= core_out;
                pad_oe_n_ff <= core_oe_n;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_upd_dr_fall;
        tck_fall && state_ff == tap_pkg::UPDATE_DR && sel_bsr;
    endsequence

    property p_state_only_on_rise;
        !tck_rise |=> $stable(state_ff);
    endproperty
    a_state_only_on_rise: assert property (p_state_only_on_rise)
        else $error("controller moved without a rising test clock");

    property p_reset_hold;
        tck_rise && state_ff == tap_pkg::TEST_LOGIC_RESET && tms_s
            |=> state_ff == tap_pkg::TEST_LOGIC_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset state left with mode select high");

    property p_ir_capture;
        tck_rise && state_ff == tap_pkg::CAPTURE_IR
            |=> ir_sh_ff == tap_pkg::IR_CAPTURE_PAT ##1 $stable(ir_sh_ff) [*2];
    endproperty
    a_ir_capture: assert property (p_ir_capture)
        else $error("instruction capture pattern wrong");

    property p_ir_update;
        tck_fall && state_ff == tap_pkg::UPDATE_IR |=> ir_ff == $past(ir_sh_ff);
    endproperty
    a_ir_update: assert property (p_ir_update)
        else $error("instruction update missed");

    property p_tdo_float;
        tck_fall && state_ff != tap_pkg::SHIFT_IR && state_ff != tap_pkg::SHIFT_DR
            |=> tdo_oe_n_ff;
    endproperty
    a_tdo_float: assert property (p_tdo_float)
        else $error("serial output driven outside shifting");

    property p_tdo_ir_lsb;
        tck_fall && state_ff == tap_pkg::SHIFT_IR |=> !tdo_oe_n_ff && tdo_ff == $past(ir_sh_ff[0]);
    endproperty
    a_tdo_ir_lsb: assert property (p_tdo_ir_lsb)
        else $error("serial output is not the instruction lsb");

    property p_bypass_shift;
        tck_rise && state_ff == tap_pkg::SHIFT_DR && !sel_id && !sel_bsr |=> byp_ff == $past(tdi_s);
    endproperty
    a_bypass_shift: assert property (p_bypass_shift)
        else $error("bypass stage did not take the data input");

    property p_id_capture;
        tck_rise && state_ff == tap_pkg::CAPTURE_DR && sel_id |=> id_sh_ff == ID_VALUE;
    endproperty
    a_id_capture: assert property (p_id_capture)
        else $error("identification value not captured");

    property p_highz;
        ce && ir_ff == tap_pkg::IR_HIGHZ |=> pad_oe_n_ff == '1;
    endproperty
    a_highz: assert property (p_highz)
        else $error("pins driven under the float instruction");

    property p_preload;
        s_upd_dr_fall |=> bsr_upd_ff == $past(bsr_sh_ff);
    endproperty
    a_preload: assert property (p_preload)
        else $error("boundary update stage not loaded");

    property p_tdi_ignored;
        tck_rise && state_ff != tap_pkg::SHIFT_IR && state_ff != tap_pkg::CAPTURE_IR
            |=> $stable(ir_sh_ff);
    endproperty
    a_tdi_ignored: assert property (p_tdi_ignored)
        else $error("instruction stage changed outside shifting");

endmodule : tap_unit

// file: bench/tap_tester.sv
`timescale 1ns/1ps
module tap_tester (
    // pacing clock
    input wire logic core_clk,
    // link pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // link clock rests low between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one link period is 8 core cycles, far below the core rate
    task automatic tick(input logic m, input logic d, input logic use_d, output logic o);
        tms = m;
        tdi = use_d ? d : ~tdi;
        repeat (4) @(negedge core_clk);
        o = tdo;
        tck = 1'b1;
        repeat (4) @(negedge core_clk);
        tck = 1'b0;
    endtask : tick
endmodule : tap_tester

// file: bench/boundary_scan_test_port_test.sv
`timescale 1ns/1ps
module boundary_scan_test_port_test;
    localparam int BSR = 8;
    // arbitrary identity values
    localparam logic [3:0] id_ver = 4'h3;
    localparam logic [15:0] id_part = 16'h0042;
    localparam logic [10:0] id_maker = 11'h055;
    localparam logic [31:0] id_exp = {id_ver, id_part, id_maker, 1'b1};

    logic core_clk, nrst, ce, trst_n, tck, tms, tdi, tdo_q, tdo_oe_n, upd_valid, upd_ready;
    logic [BSR-1:0] pad_in, core_out, core_oe_n, pad_out, pad_oe_n, upd_data;
    wire tdo_pin;
    int miscompares;
    int cmp_count;

    assign tdo_pin = tdo_oe_n ? 1'bz : tdo_q;

    tap_tester tester (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

    tap_unit #(.BSR_LEN(BSR), .FIFO_DEPTH(16), .ID_VERSION(id_ver), .ID_PART(id_part),
        .ID_MAKER(id_maker)) DUT (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_ff(tdo_q), .tdo_oe_n_ff(tdo_oe_n), .pad_in(pad_in),
        .core_out(core_out), .core_oe_n(core_oe_n), .pad_out_ff(pad_out),
        .pad_oe_n_ff(pad_oe_n), .upd_valid_ff(upd_valid), .upd_data_ff(upd_data),
        .upd_ready(upd_ready));

    always #20 core_clk = ~core_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // full scan from run-test/idle back to run-test/idle, optional pause
    task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
        input int pause_at, output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        tester.tick(1'b1, 1'b0, 1'b0, o);
        if (is_ir)
            tester.tick(1'b1, 1'b0, 1'b0, o);
        tester.tick(1'b0, 1'b0, 1'b0, o);
        tester.tick(1'b0, 1'b0, 1'b0, o);
        check("tdo while capturing", 32'h0000000z, {31'h0, o});
        for (int i = 0; i < n; i++)
        begin
            tester.tick((i == n - 1) || (i == pause_at), din[i], 1'b1, o);
            dout[i] = o;
            if (i == pause_at)
            begin
                tester.tick(1'b0, 1'b0, 1'b0, o);
                tester.tick(1'b1, 1'b0, 1'b0, o);
                check("tdo while paused", 32'h0000000z, {31'h0, o});
                tester.tick(1'b0, 1'b0, 1'b0, o);
            end
        end
        tester.tick(1'b1, 1'b0, 1'b0, o);
        tester.tick(1'b0, 1'b0, 1'b0, o);
    endtask : scan

    task automatic load_ir(input logic [3:0] op);
        logic [31:0] d;
        scan(1'b1, 4, {28'h0, op}, -1, d);
        check("instruction capture", 32'h00000001, d);
    endtask : load_ir

    // wait for a stream word, compare it, then accept it
    task automatic pop(input logic [7:0] exp);
        int k;
        k = 0;
        while (upd_valid !== 1'b1 && k < 40)
        begin
            @(negedge core_clk);
            k++;
        end
        check("update word", {23'h0, 1'b1, exp}, {23'h0, upd_valid, upd_data});
        upd_ready = 1'b1;
        @(negedge core_clk);
        upd_ready = 1'b0;
        @(negedge core_clk);
    endtask : pop

    task automatic test_idcode();
        logic [31:0] d;
        logic o;
        tester.tick(1'b0, 1'b0, 1'b0, o);
        check("tdo in reset state", 32'h0000000z, {31'h0, o});
        check("pads follow core", {16'h0, core_out, core_oe_n}, {16'h0, pad_out, pad_oe_n});
        scan(1'b0, 32, 32'h0, 15, d);
        check("identification", id_exp, d);
        $display("test idcode done");
    endtask : test_idcode

    task automatic test_bypass();
        logic [31:0] d;
        for (int k = 0; k < 2; k++)
        begin
            load_ir(k == 0 ? tap_pkg::IR_BYPASS : 4'h7);
            scan(1'b0, 8, 32'h0000005b, -1, d);
            check("bypass path", 32'h000000b6, d);
        end
        $display("test bypass done");
    endtask : test_bypass

    task automatic test_sample_extest();
        logic [31:0] d;
        logic o;
        pad_in = 8'ha5;
        load_ir(tap_pkg::IR_SAMPLE);
        scan(1'b0, 8, 32'h0000003c, -1, d);
        check("captured pins", 32'h000000a5, d);
        pop(8'h3c);
        load_ir(tap_pkg::IR_EXTEST);
        check("pins from preload", 32'h0000003c, {24'h0, pad_out});
        load_ir(tap_pkg::IR_HIGHZ);
        check("all pins floating", 32'h000000ff, {24'h0, pad_oe_n});
        for (int i = 0; i < 5; i++)
            tester.tick(1'b1, 1'b0, 1'b0, o);
        tester.tick(1'b0, 1'b0, 1'b0, o);
        check("pads after reset state", {16'h0, core_out, core_oe_n}, {16'h0, pad_out, pad_oe_n});
        $display("test sample extest done");
    endtask : test_sample_extest

    // far side stalls while 18 updates arrive
    task automatic test_fifo();
        logic [31:0] d;
        load_ir(tap_pkg::IR_SAMPLE);
        for (int i = 0; i < 18; i++)
            scan(1'b0, 8, 32'(i), -1, d);
        ce = 1'b0;
        upd_ready = 1'b1;
        repeat (3) @(negedge core_clk);
        check("word held while frozen", 32'h00000100, {23'h0, upd_valid, upd_data});
        upd_ready = 1'b0;
        ce = 1'b1;
        for (int i = 0; i < 16; i++)
            pop(8'(i));
        repeat (4) @(negedge core_clk);
        pop(8'h10);
        repeat (4) @(negedge core_clk);
        check("word beyond capacity", 32'h0, {31'h0, upd_valid});
        $display("test fifo done");
    endtask : test_fifo

    task automatic test_trst_mid();
        logic [31:0] d;
        logic o;
        load_ir(tap_pkg::IR_BYPASS);
        for (int i = 0; i < 6; i++)
            tester.tick(i < 2, 1'b1, i > 3, o);
        trst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        check("tdo during test reset", 32'h0000000z, {31'h0, tdo_pin});
        trst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        tester.tick(1'b0, 1'b0, 1'b0, o);
        scan(1'b0, 32, 32'h0, -1, d);
        check("identification after test reset", id_exp, d);
        $display("test reset in shift done");
    endtask : test_trst_mid

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        core_clk = 1'b0;
        ce = 1'b1;
        nrst = 1'b0;
        trst_n = 1'b0;
        upd_ready = 1'b0;
        pad_in = 8'h00;
        core_out = 8'h96;
        core_oe_n = 8'h0f;
        miscompares = 0;
        cmp_count = 0;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        trst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        test_idcode();
        test_bypass();
        test_sample_extest();
        test_fifo();
        test_trst_mid();
        print_verdict();
    end

    // about 3500 core cycles expected
    initial
    begin
        #1000000;
        miscompares++;
        print_verdict();
    end
endmodule : boundary_scan_test_port_test
